// >>> design/ptm_top.sv
// three channel pwm timer with plain register port
// assumes standby_i is a level from the same clock domain
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps

module ptm_top
  import ptm_pkg::*;
#(
  parameter int NUM_CH = 3
)
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic standby_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic [NUM_CH-1:0] pulse_out_o,
  output logic [NUM_CH-1:0] pulse_oe_o
);

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [PTM_PRESCALE_W-1:0] prescale;
    ptm_chan_s [NUM_CH-1:0] chan;
    logic [7:0] rdata;
  } ptm_state_s;

  ptm_state_s state;
  ptm_state_s next_state;
  logic rst_n;
  ptm_bus_s bus;
  logic [7:0] tick_set;

  assign bus = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

  // ****************************************
  // reset synchroniser
  // ****************************************
  logic [1:0] rst_ff;
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rst_ff <= 2'h0;
    else
      rst_ff <= {rst_ff[0], 1'b1};
  end
  assign rst_n = rst_ff[1];

  // ****************************************
  // functions
  // ****************************************
  function automatic logic [7:0] ch_base(input logic [15:0] a);
    logic [15:0] off;
    off = a - PTM_CH1_CONTROL;
    ch_base = {6'h0, off[3:2]};
  endfunction

  function automatic logic [7:0] ctrl_read(input ptm_ctrl_s c);
    ctrl_read = {c.enable, c.polarity_select, 3'h0, c.clk_sel} | PTM_CONTROL_FIXED; // [R15]
  endfunction

  // prescaled tick for a count of the free divider
  always_comb
  begin
    tick_set = 8'h00;
    tick_set[0] = (state.prescale[0] == 1'b1); // [R14] [R19]
    tick_set[1] = (state.prescale[2:0] == 3'h7);
    tick_set[2] = (state.prescale[4:0] == 5'h1f);
    tick_set[3] = (state.prescale[6:0] == 7'h7f);
    tick_set[4] = (state.prescale[7:0] == 8'hff);
    tick_set[5] = (state.prescale[9:0] == 10'h3ff);
    tick_set[6] = (state.prescale[10:0] == 11'h7ff);
    tick_set[7] = (state.prescale == 12'hfff);
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    logic [15:0] off;
    logic [1:0] sel;
    logic [1:0] reg_idx;
    logic tick;
    next_state = state;
    off = 16'h0000;
    sel = 2'h0;
    reg_idx = 2'h0;
    tick = 1'b0;
    next_state.prescale = state.prescale + 12'h001;
    next_state.rdata = 8'h00;
    for (int i = 0; i < NUM_CH; i++)
    begin
      off = bus.addr - PTM_CH1_CONTROL;
      sel = off[3:2];
      reg_idx = off[1:0];
      tick = tick_set[state.chan[i].ctrl.clk_sel]; // [R14]
      if (state.chan[i].ctrl.enable && tick)
      begin
        if (state.chan[i].period_counter == PTM_COUNT_LAST)
        begin
          next_state.chan[i].period_counter = PTM_COUNTER_RESET; // [R2]
          next_state.chan[i].duty_active = state.chan[i].duty_pending; // [R9]
        end
        else
        begin
          next_state.chan[i].period_counter = state.chan[i].period_counter + 8'h01; // [R2]
        end
        if (state.chan[i].period_counter == 8'h00 && state.chan[i].duty_active != 8'h00)
          next_state.chan[i].level = 1'b1; // [R5]
        if (state.chan[i].period_counter + 8'h01 == state.chan[i].duty_active)
          next_state.chan[i].level = 1'b0; // [R6] [R18]
      end
      if (bus.wr && bus.addr >= PTM_CH1_CONTROL && bus.addr <= PTM_CH3_COUNTER
          && sel == 2'(i) && reg_idx != 2'h3)
      begin
        unique case (reg_idx)
          2'h0:
          begin
            next_state.chan[i].ctrl.enable = bus.wdata[PTM_ENABLE_BIT];
            next_state.chan[i].ctrl.polarity_select = bus.wdata[PTM_POLARITY_BIT];
            next_state.chan[i].ctrl.clk_sel = bus.wdata[2:0];
          end
          2'h1:
          begin
            next_state.chan[i].duty_pending = bus.wdata; // [R9]
            if (!state.chan[i].ctrl.enable)
              next_state.chan[i].duty_active = bus.wdata; // [R10]
          end
          2'h2:
            next_state.chan[i].period_counter = bus.wdata; // [R16]
          default:
          begin
          end
        endcase
      end
      if (!next_state.chan[i].ctrl.enable)
      begin
        next_state.chan[i].period_counter = PTM_COUNTER_RESET; // [R3] [R4]
        next_state.chan[i].level = 1'b0;
      end
      if (bus.rd && bus.addr >= PTM_CH1_CONTROL && bus.addr <= PTM_CH3_COUNTER
          && sel == 2'(i))
      begin
        unique case (reg_idx)
          2'h0: next_state.rdata = ctrl_read(state.chan[i].ctrl); // [R15]
          2'h1: next_state.rdata = state.chan[i].duty_active; // [R11]
          2'h2: next_state.rdata = state.chan[i].period_counter;
          default: next_state.rdata = 8'h00;
        endcase
      end
      if (standby_i)
      begin
        next_state.chan[i].ctrl = '0; // [R4] [R12] [R15]
        next_state.chan[i].duty_active = PTM_DUTY_RESET;
        next_state.chan[i].duty_pending = PTM_DUTY_RESET;
        next_state.chan[i].period_counter = PTM_COUNTER_RESET;
        next_state.chan[i].level = 1'b0;
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state <= '0;
      for (int i = 0; i < NUM_CH; i++)
      begin
        state.chan[i].duty_active <= PTM_DUTY_RESET; // [R12]
        state.chan[i].duty_pending <= PTM_DUTY_RESET;
        state.chan[i].period_counter <= PTM_COUNTER_RESET; // [R4]
      end
    end
    else
      state <= next_state;
  end

  // ****************************************
  // outputs
  // ****************************************
  logic [NUM_CH-1:0] logical;
  always_comb
  begin
    for (int i = 0; i < NUM_CH; i++)
    begin
      if (state.chan[i].duty_active == 8'h00)
        logical[i] = 1'b0; // [R7]
      else if (state.chan[i].duty_active >= PTM_DUTY_FULL)
        logical[i] = 1'b1; // [R8]
      else
        logical[i] = state.chan[i].level;
      pulse_out_o[i] = logical[i] ^ state.chan[i].ctrl.polarity_select; // [R13]
      pulse_oe_o[i] = state.chan[i].ctrl.enable; // [R1] [R3]
    end
  end
  assign rdata_o = state.rdata;

  // ****************************************
  // checks
  // ****************************************
  chk_counter_range: assert property (@(posedge clk_i) disable iff (!rst_n) // [R2]
    state.chan[0].period_counter <= PTM_COUNT_LAST || $past(wr_i))
    else $error("counter beyond last count");
  chk_disabled_zero: assert property (@(posedge clk_i) disable iff (!rst_n) // [R3]
    !state.chan[0].ctrl.enable |-> state.chan[0].period_counter == 8'h00 && !pulse_oe_o[0])
    else $error("disabled channel not cleared");
  chk_duty_zero_low: assert property (@(posedge clk_i) disable iff (!rst_n) // [R7]
    state.chan[1].duty_active == 8'h00 |-> logical[1] == 1'b0)
    else $error("zero duty not low");
  chk_duty_full_high: assert property (@(posedge clk_i) disable iff (!rst_n) // [R8]
    state.chan[1].duty_active >= PTM_DUTY_FULL |-> logical[1])
    else $error("full duty not high");
  chk_duty_hold: assert property (@(posedge clk_i) disable iff (!rst_n) // [R9]
    state.chan[0].ctrl.enable && $past(state.chan[0].ctrl.enable)
    && state.chan[0].period_counter != 8'h00
    |-> $stable(state.chan[0].duty_active))
    else $error("active duty changed mid period");
  chk_duty_direct: assert property (@(posedge clk_i) disable iff (!rst_n) // [R10]
    wr_i && addr_i == PTM_CH1_DUTY && !state.chan[0].ctrl.enable && !standby_i
    |=> state.chan[0].duty_active == $past(wdata_i))
    else $error("disabled duty write not immediate");
  chk_rise_at_one: assert property (@(posedge clk_i) disable iff (!rst_n) // [R5]
    state.chan[2].ctrl.enable && $rose(state.chan[2].level)
    |-> state.chan[2].period_counter == 8'h01)
    else $error("output rose off step one");
  chk_polarity_pin: assert property (@(posedge clk_i) disable iff (!rst_n) // [R13]
    pulse_out_o[0] == (logical[0] ^ state.chan[0].ctrl.polarity_select))
    else $error("pin sense wrong");
  chk_ctrl_fixed: assert property (@(posedge clk_i) disable iff (!rst_n) // [R15]
    rd_i && addr_i == PTM_CH2_CONTROL |=> rdata_o[5:3] == 3'h7)
    else $error("reserved bits not one");
  chk_standby_init: assert property (@(posedge clk_i) disable iff (!rst_n) // [R12]
    standby_i |=> state.chan[2].duty_active == PTM_DUTY_RESET)
    else $error("standby did not init duty");

  chk_counter_range1: assert property (@(posedge clk_i) disable iff (!rst_n) // [R2]
    state.chan[1].period_counter <= PTM_COUNT_LAST || $past(wr_i))
    else $error("counter two beyond last count");
  chk_counter_range2: assert property (@(posedge clk_i) disable iff (!rst_n) // [R2]
    state.chan[2].period_counter <= PTM_COUNT_LAST || $past(wr_i))
    else $error("counter three beyond last count");
  chk_disabled_zero1: assert property (@(posedge clk_i) disable iff (!rst_n) // [R3]
    !state.chan[1].ctrl.enable |-> state.chan[1].period_counter == 8'h00 && !pulse_oe_o[1])
    else $error("disabled channel two not cleared");
  chk_disabled_zero2: assert property (@(posedge clk_i) disable iff (!rst_n) // [R3]
    !state.chan[2].ctrl.enable |-> state.chan[2].period_counter == 8'h00 && !pulse_oe_o[2])
    else $error("disabled channel three not cleared");
  chk_counter_step: assert property (@(posedge clk_i) disable iff (!rst_n) // [R2]
    state.chan[0].ctrl.enable && $past(state.chan[0].ctrl.enable) && !$past(wr_i)
    && $past(tick_set[state.chan[0].ctrl.clk_sel]) && $past(state.chan[0].period_counter) != PTM_COUNT_LAST
    |-> state.chan[0].period_counter == $past(state.chan[0].period_counter) + 8'h01)
    else $error("counter did not step on tick");
  chk_counter_hold: assert property (@(posedge clk_i) disable iff (!rst_n) // [R2]
    state.chan[0].ctrl.enable && $past(state.chan[0].ctrl.enable) && !$past(wr_i)
    && !$past(tick_set[state.chan[0].ctrl.clk_sel])
    |-> $stable(state.chan[0].period_counter))
    else $error("counter moved without tick");
  chk_fall_at_duty: assert property (@(posedge clk_i) disable iff (!rst_n) // [R6]
    state.chan[0].ctrl.enable && $fell(state.chan[0].level)
    |-> state.chan[0].period_counter == $past(state.chan[0].duty_active)
    || state.chan[0].period_counter == 8'h00)
    else $error("output fell off duty count");
  chk_rise_at_one0: assert property (@(posedge clk_i) disable iff (!rst_n) // [R5]
    state.chan[0].ctrl.enable && $rose(state.chan[0].level)
    |-> state.chan[0].period_counter == 8'h01)
    else $error("channel one rose off step one");
  chk_read_duty: assert property (@(posedge clk_i) disable iff (!rst_n) // [R11]
    rd_i && addr_i == PTM_CH3_DUTY |=> rdata_o == $past(state.chan[2].duty_active))
    else $error("duty read not active value");
  chk_rdata_idle: assert property (@(posedge clk_i) disable iff (!rst_n) // [R11]
    !rd_i |=> rdata_o == 8'h00)
    else $error("read data outside read slot");
  chk_tick_div2: assert property (@(posedge clk_i) disable iff (!rst_n) // [R19]
    tick_set[0] |=> !tick_set[0] ##1 tick_set[0])
    else $error("half rate tick wrong");
  chk_tick_div8: assert property (@(posedge clk_i) disable iff (!rst_n) // [R14]
    tick_set[1] |-> ##8 tick_set[1])
    else $error("eighth rate tick wrong");
  chk_tick_div128: assert property (@(posedge clk_i) disable iff (!rst_n) // [R14]
    tick_set[3] |-> ##128 tick_set[3])
    else $error("slow tick wrong");
  chk_duty_zero_low0: assert property (@(posedge clk_i) disable iff (!rst_n) // [R7]
    state.chan[0].duty_active == 8'h00 |-> logical[0] == 1'b0)
    else $error("zero duty not low on channel one");
  chk_duty_full_high0: assert property (@(posedge clk_i) disable iff (!rst_n) // [R8]
    state.chan[0].duty_active >= PTM_DUTY_FULL |-> logical[0])
    else $error("full duty not high on channel one");
  chk_polarity_pin1: assert property (@(posedge clk_i) disable iff (!rst_n) // [R13]
    pulse_out_o[1] == (logical[1] ^ state.chan[1].ctrl.polarity_select))
    else $error("pin sense wrong on channel two");
  chk_duty_direct2: assert property (@(posedge clk_i) disable iff (!rst_n) // [R10]
    wr_i && addr_i == PTM_CH3_DUTY && !state.chan[2].ctrl.enable && !standby_i
    |=> state.chan[2].duty_active == $past(wdata_i))
    else $error("disabled duty write not immediate on channel three");
  chk_ctrl_fixed1: assert property (@(posedge clk_i) disable iff (!rst_n) // [R15]
    rd_i && addr_i == PTM_CH1_CONTROL |=> rdata_o[5:3] == 3'h7)
    else $error("reserved bits not one on channel one");
  chk_standby_ctrl: assert property (@(posedge clk_i) disable iff (!rst_n) // [R15]
    standby_i |=> !state.chan[0].ctrl.enable && state.chan[0].ctrl.clk_sel == 3'h0)
    else $error("standby did not init control");

  cov_standby: cover property (@(posedge clk_i) disable iff (!rst_n)
    standby_i ##1 !standby_i);
  cov_full: cover property (@(posedge clk_i) disable iff (!rst_n)
    state.chan[0].ctrl.enable && state.chan[0].duty_active >= PTM_DUTY_FULL);
  cov_wrap: cover property (@(posedge clk_i) disable iff (!rst_n)
    state.chan[0].period_counter == PTM_COUNT_LAST ##1 state.chan[0].period_counter == 8'h00);
  cov_fall: cover property (@(posedge clk_i) disable iff (!rst_n)
    $fell(state.chan[0].level));
  cov_neg: cover property (@(posedge clk_i) disable iff (!rst_n)
    state.chan[1].ctrl.enable && state.chan[1].ctrl.polarity_select);

endmodule

// >>> include/ptm_pkg.sv
// package of constants and types for the three channel pwm timer
// assumes a 10 mhz system clock and an 8-bit register port with byte addresses
//
// Summary of operation
// R1: three identical channels, 8-bit counter, one output
// R2: counter counts 0 to 249 on prescaled ticks
// R3: enable low holds counter zero, output off
// R4: counter zero on reset, standby, disable
// R5: nonzero duty sets output at step 0-1
// R6: output clears when counter reaches duty
// R7: duty zero keeps output low
// R8: duty 250 to 255 keeps output high
// R9: duty buffered, loaded when counter wraps
// R10: while disabled, duty write takes effect at once
// R11: duty read returns active value
// R12: duty resets to all ones
// R13: polarity bit inverts pin sense
// R14: clock select picks one of eight divisions
// R15: control resets 0x38, bits 5-3 read one
// R16: software should not write the counters
// R17: set clock and polarity before enabling
// R18: duty steps of one in 250 counts
// R19: prescaled clocks are shared enable pulses
package ptm_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam logic [15:0] PTM_CH1_CONTROL = 16'hfec0;
  localparam logic [15:0] PTM_CH1_DUTY = 16'hfec1;
  localparam logic [15:0] PTM_CH1_COUNTER = 16'hfec2;
  localparam logic [15:0] PTM_CH2_CONTROL = 16'hfec4;
  localparam logic [15:0] PTM_CH2_DUTY = 16'hfec5;
  localparam logic [15:0] PTM_CH2_COUNTER = 16'hfec6;
  localparam logic [15:0] PTM_CH3_CONTROL = 16'hfec8;
  localparam logic [15:0] PTM_CH3_DUTY = 16'hfec9;
  localparam logic [15:0] PTM_CH3_COUNTER = 16'hfeca;

  // ****************************************
  // fields and reset values
  // ****************************************
  localparam int PTM_ENABLE_BIT = 7;
  localparam int PTM_POLARITY_BIT = 6;
  localparam logic [7:0] PTM_CONTROL_RESET = 8'h38;
  localparam logic [7:0] PTM_CONTROL_FIXED = 8'h38;
  localparam logic [7:0] PTM_DUTY_RESET = 8'hff;
  localparam logic [7:0] PTM_COUNTER_RESET = 8'h00;
  localparam logic [7:0] PTM_COUNT_LAST = 8'hf9;
  localparam logic [7:0] PTM_DUTY_FULL = 8'hfa;
  localparam int PTM_PRESCALE_W = 12;

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic enable;
    logic polarity_select;
    logic [2:0] clk_sel;
  } ptm_ctrl_s;

  typedef struct packed {
    ptm_ctrl_s ctrl;
    logic [7:0] duty_active;
    logic [7:0] duty_pending;
    logic [7:0] period_counter;
    logic level;
  } ptm_chan_s;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ptm_bus_s;

endpackage

// >>> tb/ptm_load.sv
// external load on the three pulse pins
// assumes a pull-down holds each pin low while the timer leaves it undriven
`timescale 1ns/100ps

module ptm_load
(
  input wire logic [2:0] drive_i,
  input wire logic [2:0] oe_i,
  output logic [2:0] pin_o
);
  // undriven pins fall to the pull-down level
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      pin_o[i] = oe_i[i] ? drive_i[i] : 1'b0;
    end
  end
endmodule

// >>> tb/ptm_top_tb.sv
// self-checking bench for the three channel pwm timer
// assumes ptm_pkg register map and a load model on the pins
`timescale 1ns/100ps

module ptm_top_tb
  import ptm_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic standby_i = 1'b0;
  logic [15:0] addr_i = '0;
  logic [7:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic [2:0] pulse_out_o;
  logic [2:0] pulse_oe_o;
  logic [2:0] pin;
  int fails = 0;
  int samples_checked = 0;
  int seed = 88493;
  int ctl[3];
  int act[3];
  int pend[3];
  int dv[8] = '{2, 8, 32, 128, 256, 1024, 2048, 4096};

  always #50 clk_i = ~clk_i;

  ptm_top #(.NUM_CH(3)) DUT (.clk_i(clk_i), .rst_n_i(rst_n_i), .standby_i(standby_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .pulse_out_o(pulse_out_o), .pulse_oe_o(pulse_oe_o));
  ptm_load u_load (.drive_i(pulse_out_o), .oe_i(pulse_oe_o), .pin_o(pin));

  // ****************************************
  // tasks
  // ****************************************
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      fails++;
      $display("ERROR %s expected %0d seen %0d", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    int c;
    c = (a - PTM_CH1_CONTROL) >> 2;
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
    if (a[1:0] == 2'd0)
      ctl[c] = {d[7:6], 3'b111, d[2:0]};
    else if (ctl[c][7])
      pend[c] = d;
    else
      act[c] = d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    d = rdata_o;
  endtask

  function automatic logic [7:0] expv(input logic [15:0] a);
    int c;
    c = (a - PTM_CH1_CONTROL) >> 2;
    case (a[1:0])
      2'd0: return 8'(ctl[c]);
      2'd1: return 8'(act[c]);
      default: return 8'h00;
    endcase
  endfunction

  task automatic waitlvl(input int ch, input logic v, output int n);
    n = 0;
    while (pin[ch] !== v)
    begin
      @(negedge clk_i);
      n++;
      if (n > 20000)
      begin
        fails++;
        print_verdict();
      end
    end
  endtask

  // active time and period of the logical one, seen at the pin
  task automatic measure(input int ch, input logic lvl, output int hi, output int per);
    int n;
    waitlvl(ch, !lvl, n);
    waitlvl(ch, lvl, n);
    waitlvl(ch, !lvl, hi);
    waitlvl(ch, lvl, n);
    per = hi + n;
  endtask

  // ****************************************
  // main sequence
  // ****************************************
  initial
  begin
    int d;
    int hi;
    int per;
    logic [15:0] b;
    logic [7:0] v;
    logic [7:0] v2;
    for (int i = 0; i < 3; i++)
    begin
      ctl[i] = 8'h38;
      act[i] = 8'hff;
    end
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    for (b = PTM_CH1_CONTROL; b <= 16'hfecb; b++)
    begin
      rd(b, v);
      check("reset value", v, expv(b));
    end
    for (int ch = 0; ch < 3; ch++)
    begin
      b = PTM_CH1_CONTROL + 16'(ch * 4);
      d = $random(seed);
      wr(b, 8'(d) & 8'h47);
      wr(b + 1, 8'(d >> 8));
      rd(b, v);
      check("control", v, expv(b));
      rd(b + 1, v);
      check("duty idle", v, expv(b + 1));
    end
    for (int ch = 0; ch < 2; ch++)
    begin
      b = PTM_CH1_CONTROL + 16'(ch * 4);
      d = 2 + {$random(seed)} % 248;
      wr(b + 1, 8'(d));
      wr(b, 8'(ch << 6));
      wr(b, 8'h80 | 8'(ch << 6));
      measure(ch, ch == 0, hi, per);
      check("active time", hi, (d - 1) * 2);
      check("period", per, 500);
      d = 2 + {$random(seed)} % 248;
      wr(b + 1, 8'(d));
      rd(b + 1, v);
      check("duty held", v, expv(b + 1));
      repeat (520) @(posedge clk_i);
      act[ch] = pend[ch];
      rd(b + 1, v);
      check("duty loaded", v, expv(b + 1));
      measure(ch, ch == 0, hi, per);
      check("new active time", hi, (d - 1) * 2);
      wr(b, 8'(ch << 6));
      rd(b + 2, v);
      check("stopped count", v, 8'h00);
      check("pin released", pulse_oe_o[ch], 1'b0);
    end
    for (int k = 0; k < 2; k++)
    begin
      d = (k == 0) ? 0 : 250 + {$random(seed)} % 6;
      wr(PTM_CH1_DUTY, 8'(d));
      wr(PTM_CH1_CONTROL, 8'h80);
      hi = 0;
      repeat (4) @(negedge clk_i);
      repeat (510)
      begin
        @(negedge clk_i);
        hi += pin[0];
      end
      check("flat output", hi, k * 510);
      wr(PTM_CH1_CONTROL, 8'h00);
    end
    // counter steps exactly twice in two prescaled periods, every code
    for (int c = 0; c < 8; c++)
    begin
      wr(PTM_CH3_CONTROL, 8'(c));
      wr(PTM_CH3_CONTROL, 8'h80 | 8'(c));
      rd(PTM_CH3_COUNTER, v);
      repeat (2 * dv[c] - 2) @(posedge clk_i);
      rd(PTM_CH3_COUNTER, v2);
      check("count step", (v2 < 250) ? (v2 - v + 250) % 250 : 999, 2);
    end
    @(posedge clk_i);
    standby_i <= 1'b1;
    @(posedge clk_i);
    standby_i <= 1'b0;
    ctl[2] = 8'h38;
    act[2] = 8'hff;
    for (b = PTM_CH3_CONTROL; b <= PTM_CH3_COUNTER; b++)
    begin
      rd(b, v);
      check("standby value", v, expv(b));
    end
    print_verdict();
  end

  initial
  begin
    #9000000;
    fails++;
    print_verdict();
  end
endmodule
